// [core/pss_regs.svh]
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
// ----------------------------------------
// constants of the sleep/wake supervisor
// ----------------------------------------
`define PSS_CLK_MHZ         250
`define PSS_TICK_US         1000
`define PSS_TICK_CYC        (`PSS_CLK_MHZ * `PSS_TICK_US)
`define PSS_WAKE_BELOW      2'h0
`define PSS_WAKE_ABOVE      2'h1
`define PSS_WAKE_BEYOND     2'h2
`define PSS_FUNC_BYPASS     8'h17
`define PSS_FUNC_GAINSWAP   8'h18
`endif

// [core/pss_pkg.sv]
// ----------------------------------------
// types of the sleep/wake supervisor
// ----------------------------------------
package pss_pkg;
	typedef enum logic [4:0] {
		PSS_IDLE   = 5'h01,
		PSS_PREREG = 5'h02,
		PSS_PID    = 5'h04,
		PSS_SLEEP  = 5'h08,
		PSS_TRIP   = 5'h10
	} pss_state_t;

	// settings from the parameter store
	typedef struct packed {
		logic [15:0] prereg_target_frequency;
		logic [15:0] prereg_exit_level;
		logic [15:0] prereg_fail_delay;
		logic [15:0] sleep_entry_delay;
		logic [15:0] sleep_entry_frequency;
		logic [15:0] wake_threshold_level;
		logic [1:0]  wake_criterion_select;
	} pss_cfg_t;
endpackage : pss_pkg

// [core/pss_hold_timer.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pss_regs.svh"
// ----------------------------------------
// qualified hold timer in millisecond ticks
// ----------------------------------------
module pss_hold_timer #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// timing
	input  wire logic         tick,
	input  wire logic         qual,
	input  wire logic [W-1:0] limit,
	// result
	output logic              expired
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} pss_tmr_t;
	pss_tmr_t st_ff;
	pss_tmr_t nxt_st;

	// restart from zero whenever the condition lapses
	always_comb begin
		nxt_st = st_ff;
		if (!qual)
			nxt_st.cnt = '0;
		else if (tick && st_ff.cnt != limit)
			nxt_st.cnt = st_ff.cnt + 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign expired = qual && (limit != '0) && (st_ff.cnt == limit);

	a_timer_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
		!qual |=> st_ff.cnt == '0) else $error("hold timer not cleared");
endmodule : pss_hold_timer
`default_nettype wire

// [core/pss_supervisor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pss_regs.svh"
module pss_supervisor
	import pss_pkg::*;
#(
	parameter int NIN = 7,
	parameter int W   = 16,
	parameter int TICK_CYC = `PSS_TICK_CYC
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	// commands and settings
	input  wire logic              run_cmd,
	input  wire pss_cfg_t          cfg,
	input  wire logic [NIN-1:0]    mf_in,
	input  wire logic [NIN*8-1:0]  mf_func,
	// measurements
	input  wire logic [W-1:0]      feedback,
	input  wire logic [W-1:0]      reference,
	input  wire logic [W-1:0]      out_freq,
	// drive outputs
	output logic                   pid_enable,
	output logic                   open_loop,
	output logic [W-1:0]           open_loop_freq,
	output logic                   output_block,
	output logic                   gain_alt_sel,
	output logic                   prereg_failure_trip,
	output logic                   sleeping
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		pss_state_t   state;
		logic [31:0]  tick_cnt;
		logic         tick;
		logic         pid_enable;
		logic         open_loop;
		logic [W-1:0] open_loop_freq;
		logic         output_block;
		logic         gain_alt_sel;
		logic         trip;
	} pss_st_t;
	pss_st_t st_ff;
	pss_st_t nxt_st;

	logic [NIN-1:0] byp_hit;
	logic [NIN-1:0] gsw_hit;
	logic           bypass;
	logic           gswap;
	logic           above_exit;
	logic           wake_ok;
	logic [W:0]     err;
	logic           fail_exp;
	logic           sleep_exp;

	// ----------------------------------------
	// multi-function input decode
	// ----------------------------------------
	for (genvar i = 0; i < NIN; i++) begin : g_in
		assign byp_hit[i] = mf_in[i] && mf_func[i*8 +: 8] == `PSS_FUNC_BYPASS;
		assign gsw_hit[i] = mf_in[i] && mf_func[i*8 +: 8] == `PSS_FUNC_GAINSWAP;
	end
	assign bypass = |byp_hit;
	assign gswap  = |gsw_hit;

	// ----------------------------------------
	// comparisons
	// ----------------------------------------
	assign above_exit = feedback > cfg.prereg_exit_level;
	// signed difference so a feedback above reference never wakes in mode 2
	assign err = {1'b0, reference} - {1'b0, feedback};

	// wake criterion; code 3 never wakes
	always_comb begin
		unique case (cfg.wake_criterion_select)
			`PSS_WAKE_BELOW:  wake_ok = feedback < cfg.wake_threshold_level;
			`PSS_WAKE_ABOVE:  wake_ok = feedback > cfg.wake_threshold_level;
			`PSS_WAKE_BEYOND: wake_ok = !err[W] &&
				err[W-1:0] > cfg.wake_threshold_level;
			default:          wake_ok = 1'b0;
		endcase
	end

	// ----------------------------------------
	// hold timers
	// ----------------------------------------
	pss_hold_timer #(.W(W)) u_fail_tmr (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tick     (st_ff.tick),
		.qual     (st_ff.state == PSS_PREREG && !above_exit && !bypass),
		.limit    (cfg.prereg_fail_delay),
		.expired  (fail_exp)
	);

	pss_hold_timer #(.W(W)) u_sleep_tmr (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tick     (st_ff.tick),
		.qual     (st_ff.state == PSS_PID && !bypass &&
			out_freq < cfg.sleep_entry_frequency),
		.limit    (cfg.sleep_entry_delay),
		.expired  (sleep_exp)
	);

	// ----------------------------------------
	// supervisor
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		// millisecond tick for the hold timers
		nxt_st.tick = 1'b0;
		if (st_ff.tick_cnt == 32'(TICK_CYC - 1)) begin
			nxt_st.tick_cnt = '0;
			nxt_st.tick     = 1'b1;
		end else begin
			nxt_st.tick_cnt = st_ff.tick_cnt + 32'h1;
		end
		unique case (st_ff.state)
			PSS_IDLE: begin
				if (run_cmd)
					nxt_st.state = PSS_PREREG;
			end
			PSS_PREREG: begin
				if (!run_cmd)
					nxt_st.state = PSS_IDLE;
				else if (fail_exp)
					nxt_st.state = PSS_TRIP;
				else if (above_exit)
					nxt_st.state = PSS_PID;
			end
			PSS_PID: begin
				if (!run_cmd)
					nxt_st.state = PSS_IDLE;
				else if (sleep_exp)
					nxt_st.state = PSS_SLEEP;
			end
			PSS_SLEEP: begin
				if (!run_cmd)
					nxt_st.state = PSS_IDLE;
				else if (wake_ok)
					nxt_st.state = PSS_PID;
			end
			PSS_TRIP: begin
				// fault latches until the run command is withdrawn
				if (!run_cmd)
					nxt_st.state = PSS_IDLE;
			end
		endcase
		// outputs follow the next state so they change with it
		nxt_st.trip         = nxt_st.state == PSS_TRIP;
		nxt_st.output_block = nxt_st.state inside {PSS_IDLE, PSS_TRIP, PSS_SLEEP};
		nxt_st.pid_enable   = nxt_st.state == PSS_PID && !bypass;
		nxt_st.open_loop    = nxt_st.state == PSS_PREREG ||
			(nxt_st.state == PSS_PID && bypass);
		nxt_st.open_loop_freq = W'(cfg.prereg_target_frequency);
		nxt_st.gain_alt_sel = gswap;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_ff       <= '0;
			st_ff.state <= PSS_IDLE;
			st_ff.output_block <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pid_enable          = st_ff.pid_enable;
	assign open_loop           = st_ff.open_loop;
	assign open_loop_freq      = st_ff.open_loop_freq;
	assign output_block        = st_ff.output_block;
	assign gain_alt_sel        = st_ff.gain_alt_sel;
	assign prereg_failure_trip = st_ff.trip;
	assign sleeping            = st_ff.state == PSS_SLEEP;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_prereg_handover: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_ff.state == PSS_PREREG && run_cmd && !fail_exp && above_exit && !bypass
		|=> pid_enable) else $error("no handover to pid");
	a_run_starts: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_ff.state == PSS_IDLE && run_cmd |=> open_loop && !output_block)
		else $error("run did not start open loop");
	a_trip_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_ff.state == PSS_PREREG && run_cmd && fail_exp
		|=> prereg_failure_trip && output_block) else $error("trip missing");
	a_sleep_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_ff.state == PSS_PID && run_cmd && sleep_exp
		|=> sleeping && output_block) else $error("sleep not entered");
	a_sleep_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
		sleeping && run_cmd && !wake_ok |=> sleeping) else $error("early wake");
	a_wake_below: assert property (@(posedge core_clk) disable iff (!rst_n)
		sleeping && run_cmd && cfg.wake_criterion_select == `PSS_WAKE_BELOW &&
		feedback < cfg.wake_threshold_level |=> !sleeping) else $error("mode 0 wake");
	a_wake_above: assert property (@(posedge core_clk) disable iff (!rst_n)
		sleeping && run_cmd && cfg.wake_criterion_select == `PSS_WAKE_ABOVE &&
		feedback > cfg.wake_threshold_level |=> !sleeping) else $error("mode 1 wake");
	a_wake_beyond: assert property (@(posedge core_clk) disable iff (!rst_n)
		sleeping && run_cmd && cfg.wake_criterion_select == `PSS_WAKE_BEYOND &&
		reference > feedback && reference - feedback > cfg.wake_threshold_level
		|=> !sleeping) else $error("mode 2 wake");
	a_bypass_halts: assert property (@(posedge core_clk) disable iff (!rst_n)
		bypass |=> !pid_enable) else $error("pid ran under bypass");
	a_bypass_release: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_ff.state == PSS_PID && run_cmd && !sleep_exp && !bypass
		|=> pid_enable) else $error("pid not resumed");
	a_gain_swap: assert property (@(posedge core_clk) disable iff (!rst_n)
		gswap |=> gain_alt_sel) else $error("alternate gain not selected");
endmodule : pss_supervisor
`default_nettype wire

// [bench/pss_drive_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// drive output stage and feedback sensor
// ----------------------------------------
module pss_drive_model #(
	parameter int W = 16
) (
	// clock
	input  wire logic         core_clk,
	// from the supervisor
	input  wire logic         open_loop,
	input  wire logic [W-1:0] open_loop_freq,
	input  wire logic         output_block,
	// bench settings of the process
	input  wire logic [W-1:0] pid_freq,
	input  wire logic [W-1:0] fb_set,
	// measurements
	output logic [W-1:0]      feedback,
	output logic [W-1:0]      out_freq
);
	// a blocked stage turns nothing; sensor lags one cycle like a real filter
	always_ff @(posedge core_clk) begin
		feedback <= fb_set;
		out_freq <= output_block ? '0 : (open_loop ? open_loop_freq : pid_freq);
	end
endmodule : pss_drive_model
`default_nettype wire

// [bench/test_pss_supervisor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pss_regs.svh"
module test_pss_supervisor;
	import pss_pkg::*;
	logic        core_clk, rst_n, run_cmd;
	pss_cfg_t    cfg;
	logic [6:0]  mf_in;
	logic [55:0] mf_func;
	logic [15:0] feedback, reference, out_freq, open_loop_freq, pid_freq, fb_set;
	logic        pid_enable, open_loop, output_block, gain_alt_sel, trip, sleeping;
	int          miscompares = 0;
	int          n_tests = 0;

	pss_supervisor #(.TICK_CYC(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
		.run_cmd(run_cmd), .cfg(cfg), .mf_in(mf_in), .mf_func(mf_func),
		.feedback(feedback), .reference(reference), .out_freq(out_freq),
		.pid_enable(pid_enable), .open_loop(open_loop), .open_loop_freq(open_loop_freq),
		.output_block(output_block), .gain_alt_sel(gain_alt_sel),
		.prereg_failure_trip(trip), .sleeping(sleeping));
	pss_drive_model drv_u (.core_clk(core_clk), .open_loop(open_loop),
		.open_loop_freq(open_loop_freq), .output_block(output_block),
		.pid_freq(pid_freq), .fb_set(fb_set), .feedback(feedback), .out_freq(out_freq));

	// ----------------------------------------
	// clock, stepping and comparing
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// inputs always move 1 ns after the edge
	task step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : step
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task end_of_test;
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	// restart from idle with a given feedback
	task go_run(input logic [15:0] fb);
		run_cmd = 1'b0;
		fb_set = fb;
		step(2);
		run_cmd = 1'b1;
	endtask : go_run

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_prereg;
		go_run(16'h0010);
		step(2);
		chk("open_loop", 16'h1, open_loop);
		chk("output_block", 16'h0, output_block);
		chk("open_loop_freq", 16'h0100, open_loop_freq);
		fb_set = 16'h0033;                                    // one above exit level
		step(4);
		chk("pid_enable", 16'h1, pid_enable);
		chk("open_loop", 16'h0, open_loop);
		$display("test prereg done");
	endtask : t_prereg
	task t_trip;
		go_run(16'h0020);
		step(18);
		chk("trip", 16'h1, trip);
		chk("output_block", 16'h1, output_block);
		$display("test trip done");
	endtask : t_trip
	// low speed runs that lapse early must not add up to a sleep
	task t_sleep_restart;
		go_run(16'h00c8);
		step(5);
		pid_freq = 16'h0010;
		step(6);
		pid_freq = 16'h0080;
		step(2);
		pid_freq = 16'h0010;
		step(6);
		chk("sleeping", 16'h0, sleeping);
		pid_freq = 16'h0080;
		$display("test restart done");
	endtask : t_sleep_restart
	task t_wake;
		logic [15:0] fb_stay [3];
		logic [15:0] fb_wake [3];
		fb_stay = '{16'h00c8, 16'h0050, 16'h00fa};
		fb_wake = '{16'h000a, 16'h00c8, 16'h0064};
		for (int m = 0; m < 3; m++) begin
			cfg.wake_criterion_select = 2'(m);
			go_run(16'h00c8);
			step(5);
			pid_freq = 16'h0010;
			fb_set = fb_stay[m];
			step(20);
			chk("sleeping", 16'h1, sleeping);
			chk("pid_enable", 16'h0, pid_enable);
			pid_freq = 16'h0080;
			step(6);
			chk("still asleep", 16'h1, output_block);
			fb_set = fb_wake[m];
			step(3);
			chk("woken pid", 16'h1, pid_enable);
		end
		// code 3 picks no wake test, so sleep must hold whatever feedback does
		cfg.wake_criterion_select = 2'h3;
		go_run(16'h00c8);
		step(5);
		pid_freq = 16'h0010;
		step(20);
		chk("sleeping", 16'h1, sleeping);
		pid_freq = 16'h0080;
		fb_set = 16'h0000;
		step(6);
		chk("mode 3 asleep", 16'h1, sleeping);
		chk("mode 3 pid", 16'h0, pid_enable);
		$display("test wake done");
	endtask : t_wake
	task t_bypass;
		go_run(16'h00c8);
		step(5);
		mf_in[3] = 1'b1;
		mf_in[5] = 1'b1;
		step(2);
		chk("open_loop", 16'h1, open_loop);
		chk("pid_enable", 16'h0, pid_enable);
		chk("gain_alt_sel", 16'h1, gain_alt_sel);
		mf_in = '0;
		step(2);
		chk("pid_enable", 16'h1, pid_enable);
		chk("gain_alt_sel", 16'h0, gain_alt_sel);
		$display("test bypass done");
	endtask : t_bypass

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		run_cmd = 1'b0;
		mf_in = '0;
		mf_func = '0;
		mf_func[3*8+:8] = `PSS_FUNC_BYPASS;
		mf_func[5*8+:8] = `PSS_FUNC_GAINSWAP;
		cfg = '{16'h0100, 16'h0032, 16'h0003, 16'h0003, 16'h0040, 16'h0064, 2'h0};
		reference = 16'h012c;
		pid_freq = 16'h0080;
		fb_set = 16'h0000;
		step(3);
		rst_n = 1'b1;
		t_prereg();
		t_trip();
		t_sleep_restart();
		t_wake();
		t_bypass();
		end_of_test();
	end
	initial begin
		#4000;
		miscompares++;
		end_of_test();
	end
endmodule : test_pss_supervisor
`default_nettype wire
